// ==== piecewise_linear_characterizer_bench.sv ====
// Self-checking bench for the characterizer
`timescale 1ns/100ps
`default_nettype none
`include "pwlc_defs.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module piecewise_linear_characterizer_bench;
  logic mclk = 1'b0, reset_n = 1'b0, in_valid, in_ready, out_valid, l1, l2, cfg_error, inv;
  logic [15:0] in_1, in_2, out_1, out_2, man_1, man_2;
  logic [335:0] curve_x, curve_y;
  logic [1:0] swap_sel, target_mode, actual_mode, sw;
  logic [4:0] npoints;
  logic [16:0] e1, e2;
  logic [33:0] ge, gg, eq[$], gq[$];
  int err_count = 0, n_checks = 0, cyc = 0, lowc = 0, n, cx[21], cy[21];
  // ----------------
  // Design and source
  // ----------------
  pwlc_characterizer dut_u (.mclk(mclk), .reset_n(reset_n), .in_valid(in_valid),
    .in_ready(in_ready), .in_1(in_1), .in_2(in_2), .out_valid(out_valid), .out_1(out_1),
    .out_2(out_2), .out_1_limit(l1), .out_2_limit(l2), .curve_x(curve_x), .curve_y(curve_y),
    .swap_sel(swap_sel), .target_mode(target_mode), .man_1(man_1), .man_2(man_2),
    .actual_mode(actual_mode), .cfg_error(cfg_error), .npoints(npoints));
  pwlc_source src_u (.mclk(mclk), .in_ready(in_ready), .in_valid(in_valid), .in_1(in_1),
    .in_2(in_2));
  always #10 mclk = ~mclk;
  // Reference curve evaluation, rising or falling search, equal counts as at or above
  function automatic logic [16:0] ev(input int v, input bit iv);
    int s[21], o[21];
    for (int i = 0; i < 21; i++) begin
      s[i] = iv ? cy[i] : cx[i];
      o[i] = iv ? cx[i] : cy[i];
    end
    // Falling Y is searched as a rising curve on negated values
    if (iv && n > 1 && cy[1] < cy[0]) begin
      v = -v;
      foreach (s[i]) s[i] = -s[i];
    end
    if (v < s[0]) return {1'b1, 16'(o[0])};
    if (v >= s[n-1]) return {1'b1, 16'(o[n-1])};
    for (int i = 0; i < n - 1; i++)
      if (v < s[i+1]) return {1'b0, 16'(o[i] + (((v - s[i]) * ((o[i+1] - o[i]) * 256 /
        (s[i+1] - s[i]))) >>> 8))};
    return 17'h00000;
  endfunction
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 60000) begin
      err_count++;
      report_and_stop();
    end
    if (!in_ready) lowc++;
    if (out_valid) gq.push_back({l2, l1, out_2, out_1});
    if (in_valid && in_ready && actual_mode == `PWLC_MODE_AUTO) begin
      e1 = ev($signed(in_1), 1'b0);
      e2 = ev($signed(in_2), inv);
      eq.push_back({e2[16], e1[16], e2[15:0], e1[15:0]});
    end
    if (in_valid && in_ready && actual_mode == `PWLC_MODE_MAN) eq.push_back({2'b00, man_2, man_1});
  end
  // Five used points, stale point left after the end marker
  task good();
    n = 5;
    foreach (cx[i]) begin
      cx[i] = (i < 5) ? 256 * i - 512 : 32767;
      cy[i] = 32767;
    end
    cx[6] = 256;
    cy[0] = -640;
    cy[1] = -128;
    cy[2] = 0;
    cy[3] = 128;
    cy[4] = 640;
  endtask
  task cfg(input logic [1:0] s, input logic [1:0] md);
    for (int i = 0; i < 21; i++) begin
      curve_x[16*i +: 16] = 16'(cx[i]);
      curve_y[16*i +: 16] = 16'(cy[i]);
    end
    swap_sel = s;
    target_mode = md;
    inv = (s == `PWLC_SWAP_ON);
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task run(input int k);
    repeat (k) src_u.q.push_back({16'($urandom_range(16'h0640)) - 16'h0320,
      16'($urandom_range(16'h0578)) - 16'h02bc});
    for (int t = 0; t < 4000; t++) begin
      @(posedge mclk);
      if (src_u.q.size() == 0 && gq.size() == eq.size()) break;
    end
    repeat (4) @(posedge mclk);
    #1;
    `CHK("count", eq.size(), gq.size())
    while (eq.size() > 0 && gq.size() > 0) begin
      ge = eq.pop_front();
      gg = gq.pop_front();
      `CHK("result", ge, gg)
    end
    eq.delete();
    gq.delete();
  endtask
  task report_and_stop();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------
  // Main sequence
  // ----------------
  initial begin
    void'($urandom(32'h51914e60));
    {curve_x, curve_y, man_1, man_2} = '0;
    swap_sel = `PWLC_SWAP_ON;
    target_mode = `PWLC_MODE_OS;
    inv = 1'b1;
    repeat (10) @(posedge mclk);
    #1 reset_n = 1'b1;
    good();
    cfg(`PWLC_SWAP_ON, `PWLC_MODE_AUTO);
    `CHK("npoints", 5'h05, npoints)
    `CHK("mode", `PWLC_MODE_AUTO, actual_mode)
    src_u.q.push_back({16'hfd80, 16'hfe00});
    src_u.q.push_back({16'h0280, 16'h0200});
    src_u.q.push_back({16'hfd7f, 16'hfdff});
    src_u.q.push_back({16'h0080, 16'h7000});
    run(40);
    `CHK("full", 1'b1, lowc > 0)
    `CHK("ready", 1'b1, in_ready)
    cfg(`PWLC_SWAP_OFF, `PWLC_MODE_AUTO);
    run(12);
    // Falling Y curve drives the inverse search downwards
    foreach (cy[i]) if (i < 5) cy[i] = -cy[i];
    cfg(`PWLC_SWAP_ON, `PWLC_MODE_AUTO);
    `CHK("cfg_error", 1'b0, cfg_error)
    run(12);
    man_1 = 16'($urandom);
    man_2 = 16'($urandom);
    cfg(`PWLC_SWAP_ON, `PWLC_MODE_MAN);
    run(6);
    cfg(`PWLC_SWAP_ON, `PWLC_MODE_OS);
    run(4);
    for (int k = 0; k < 10; k++) begin
      good();
      sw = `PWLC_SWAP_ON;
      case (k)
        0: sw = 2'h0;
        1: sw = 2'h3;
        2: cx[0] = 32767;
        3: cy[0] = 32767;
        4: cx[2] = -32768;
        5: cx[3] = cx[2];
        6: cy[3] = -1000;
        7: cy[4] = -32768;
        8: begin
          cy[3] = -1000;
          sw = `PWLC_SWAP_OFF;
        end
        default: cx[1] = 32767;
      endcase
      cfg(sw, `PWLC_MODE_AUTO);
      `CHK("cfg_error", k < 8, cfg_error)
      `CHK("mode", (k > 7) ? `PWLC_MODE_AUTO : `PWLC_MODE_OS, actual_mode)
    end
    report_and_stop();
  end
endmodule // piecewise_linear_characterizer_bench
`default_nettype wire

// ==== pwlc_characterizer.v ====
// Sample FIFO and two-channel piecewise-linear curve characterizer
// What this block does
// [RL1] Curve built from at most 21 X/Y coordinate pairs.
// [RL2] Input one is X; output one is the curve's Y for it.
// [RL3] Input two is X with inverse off, Y with inverse on.
// [RL4] Output two is Y for input two, or the X giving that Y.
// [RL5] Configurer loads 1..21 rising X values, unused points positive infinity.
// [RL6] With inverse on, configurer loads used Y strictly rising or falling.
// [RL7] One selector decides whether channel two applies the inverse curve.
// [RL8] Gradient and intercept per output come from X, Y and selector.
// [RL9] Output is input times gradient plus intercept, or a limit value.
// [RL10] Input stage settles mode and error conditions before any computation.
// [RL11] Block also passes control values through as a transmission path.
// [RL12] Config error on -inf, +inf first point, bad X order, selector, Y order.
// [RL13] Configuration error forces out-of-service mode.
// [RL14] Gradient and intercept computed only in automatic mode without error.
// [RL15] Input below first X clamps to first Y, above last X to last Y.
// [RL16] Interpolate linearly between the two adjacent points enclosing the input.
// [RL17] First positive infinity in X ends the curve; later points ignored except by the -inf error check.
`timescale 1ns/100ps
`default_nettype none
`include "pwlc_defs.vh"

// ----------------------------------------
// Sample FIFO
// ----------------------------------------
module pwlc_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Fill side
  input wire wr_valid,
  output wire wr_ready,
  input wire [WIDTH-1:0] wr_data,
  // Drain side
  output wire rd_valid,
  input wire rd_ready,
  output wire [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  // DEPTH must be a power of two so the pointers wrap by themselves
  assign wr_ready = (count != DEPTH[AW:0]);
  assign rd_valid = (count != {(AW+1){1'b0}});
  assign push = wr_valid & wr_ready;
  assign pop = rd_valid & rd_ready;
  assign rd_data = mem[rd_ptr];

  always @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= wr_data;
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // pwlc_fifo

// ----------------------------------------
// Characterizer
// ----------------------------------------
module pwlc_characterizer (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Sample input
  input wire in_valid,
  output wire in_ready,
  input wire [15:0] in_1,
  input wire [15:0] in_2,
  // Result output
  output reg out_valid,
  output reg [15:0] out_1,
  output reg [15:0] out_2,
  output reg out_1_limit,
  output reg out_2_limit,
  // Configuration
  input wire [335:0] curve_x,
  input wire [335:0] curve_y,
  input wire [1:0] swap_sel,
  input wire [1:0] target_mode,
  input wire [15:0] man_1,
  input wire [15:0] man_2,
  // Status
  output reg [1:0] actual_mode,
  output reg cfg_error,
  output reg [4:0] npoints
);
  localparam ST_IDLE = 5'h01;
  localparam ST_SEL = 5'h02;
  localparam ST_DIV = 5'h04;
  localparam ST_FAC = 5'h08;
  localparam ST_OUT = 5'h10;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [15:0] pt;
    input [335:0] vec;
    input [4:0] idx;
    begin
      pt = vec[{idx, 4'h0} +: 16];
    end
  endfunction

  function signed [47:0] mulq;
    input [15:0] a;
    input [25:0] g;
    begin
      mulq = ($signed({{32{a[15]}}, a}) * $signed({{22{g[25]}}, g})) >>> `PWLC_FRAC;
    end
  endfunction

  function [15:0] sat16;
    input signed [47:0] v;
    begin
      if (v > 48'sh7fff) begin
        sat16 = 16'h7fff;
      end else if (v < -48'sh8000) begin
        sat16 = 16'h8000;
      end else begin
        sat16 = v[15:0];
      end
    end
  endfunction

  function [16:0] abs17;
    input [16:0] v;
    begin
      abs17 = v[16] ? (~v + 17'h00001) : v;
    end
  endfunction

  // ----------------------------------------
  // Input stage: point count and configuration check
  // ----------------------------------------
  reg [4:0] next_npoints;
  reg next_err;
  reg found_end;
  reg y_inc;
  reg y_dec;
  integer i;

  always @* begin
    next_npoints = 5'h00;
    found_end = 1'b0;
    next_err = 1'b0;
    y_inc = 1'b1;
    y_dec = 1'b1;
    for (i = 0; i < `PWLC_NPTS; i = i + 1) begin
      if (pt(curve_x, i[4:0]) == `PWLC_POS_INF) begin
        found_end = 1'b1; // RL17
      end else if (!found_end) begin
        next_npoints = next_npoints + 5'h01; // RL1
      end
      if (pt(curve_x, i[4:0]) == `PWLC_NEG_INF || pt(curve_y, i[4:0]) == `PWLC_NEG_INF) begin
        next_err = 1'b1; // RL12
      end
    end
    if (pt(curve_x, 5'h00) == `PWLC_POS_INF || pt(curve_y, 5'h00) == `PWLC_POS_INF) begin
      next_err = 1'b1; // RL12
    end
    for (i = 1; i < `PWLC_NPTS; i = i + 1) begin
      if (i[4:0] < next_npoints) begin
        if ($signed(pt(curve_x, i[4:0])) <= $signed(pt(curve_x, i[4:0] - 5'h01))) begin
          next_err = 1'b1; // RL12
        end
        if ($signed(pt(curve_y, i[4:0])) <= $signed(pt(curve_y, i[4:0] - 5'h01))) begin
          y_inc = 1'b0;
        end
        if ($signed(pt(curve_y, i[4:0])) >= $signed(pt(curve_y, i[4:0] - 5'h01))) begin
          y_dec = 1'b0;
        end
      end
    end
    if (swap_sel != `PWLC_SWAP_OFF && swap_sel != `PWLC_SWAP_ON) begin
      next_err = 1'b1; // RL12
    end
    if (swap_sel == `PWLC_SWAP_ON && !y_inc && !y_dec) begin
      next_err = 1'b1; // RL12
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_error <= 1'b0;
      npoints <= 5'h00;
      actual_mode <= `PWLC_MODE_OS;
    end else begin
      cfg_error <= next_err; // RL10
      npoints <= next_npoints;
      // An unknown requested mode falls back to out of service
      if (next_err || target_mode == 2'h3) begin
        actual_mode <= `PWLC_MODE_OS; // RL13
      end else begin
        actual_mode <= target_mode; // RL10
      end
    end
  end

  // ----------------------------------------
  // Sample buffer
  // ----------------------------------------
  wire fifo_valid;
  wire fifo_pop;
  wire [31:0] fifo_data;
  reg [4:0] state;

  assign fifo_pop = (state == ST_IDLE);

  pwlc_fifo #(
    .WIDTH(32),
    .DEPTH(`PWLC_FIFO_DEPTH),
    .AW(`PWLC_FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .wr_valid(in_valid),
    .wr_ready(in_ready),
    .wr_data({in_2, in_1}),
    .rd_valid(fifo_valid),
    .rd_ready(fifo_pop),
    .rd_data(fifo_data)
  );

  // ----------------------------------------
  // Segment search for the current channel
  // ----------------------------------------
  reg ch;
  reg [15:0] s_in_1;
  reg [15:0] s_in_2;
  reg [15:0] arg;
  reg inv;
  reg desc;
  reg [335:0] a_vec;
  reg [335:0] b_vec;
  reg [4:0] k;
  integer j;

  always @* begin
    arg = ch ? s_in_2 : s_in_1; // RL2 RL3
    inv = ch && (swap_sel == `PWLC_SWAP_ON); // RL7
    a_vec = inv ? curve_y : curve_x; // RL3
    b_vec = inv ? curve_x : curve_y; // RL4
    desc = inv && (npoints > 5'h01) &&
      ($signed(pt(curve_y, 5'h01)) < $signed(pt(curve_y, 5'h00)));
    k = 5'h00;
    for (j = 0; j < `PWLC_NPTS; j = j + 1) begin
      if (j[4:0] < npoints) begin
        if (desc ? ($signed(pt(a_vec, j[4:0])) >= $signed(arg))
                 : ($signed(pt(a_vec, j[4:0])) <= $signed(arg))) begin
          k = k + 5'h01; // RL16
        end
      end
    end
  end

  // ----------------------------------------
  // Factor and output stages
  // ----------------------------------------
  reg [15:0] a0;
  reg [15:0] b0;
  reg neg;
  reg [24:0] quot;
  reg [17:0] rem;
  reg [17:0] den;
  reg [4:0] steps;
  reg signed [25:0] grad;
  reg signed [47:0] icpt;
  wire [17:0] trial;
  wire [16:0] dx;
  wire [16:0] dy;
  wire [16:0] dx_abs;
  wire [16:0] dy_abs;
  wire [15:0] a_k;
  wire [15:0] b_k;
  reg icpt_ready;

  assign trial = {rem[16:0], quot[24]};
  assign a_k = pt(a_vec, k);
  assign b_k = pt(b_vec, k);
  assign dx = {a_k[15], a_k} - {a0[15], a0};
  assign dy = {b_k[15], b_k} - {b0[15], b0};
  assign dx_abs = abs17(dx);
  assign dy_abs = abs17(dy);

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      ch <= 1'b0;
      s_in_1 <= 16'h0000;
      s_in_2 <= 16'h0000;
      a0 <= 16'h0000;
      b0 <= 16'h0000;
      neg <= 1'b0;
      quot <= 25'h0000000;
      rem <= 18'h00000;
      den <= 18'h00000;
      steps <= 5'h00;
      grad <= 26'sh0000000;
      icpt <= 48'sh000000000000;
      out_valid <= 1'b0;
      out_1 <= 16'h0000;
      out_2 <= 16'h0000;
      out_1_limit <= 1'b0;
      out_2_limit <= 1'b0;
    end else begin
      out_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (fifo_valid) begin
            s_in_1 <= fifo_data[15:0];
            s_in_2 <= fifo_data[31:16];
            ch <= 1'b0;
            if (actual_mode == `PWLC_MODE_AUTO) begin
              state <= ST_SEL; // RL14
            end else if (actual_mode == `PWLC_MODE_MAN) begin
              // Manual values are forwarded unchanged
              out_1 <= man_1; // RL11
              out_2 <= man_2; // RL11
              out_1_limit <= 1'b0;
              out_2_limit <= 1'b0;
              out_valid <= 1'b1;
            end
            // Out of service drops the sample so the buffer never wedges
          end
        end
        ST_SEL: begin
          if (actual_mode != `PWLC_MODE_AUTO) begin
            state <= ST_IDLE; // RL14
          end else if (k == 5'h00 || k == npoints) begin
            // Outside the curve: emit the end point's value
            if (ch) begin
              out_2 <= pt(b_vec, (k == 5'h00) ? 5'h00 : k - 5'h01); // RL15 RL9
              out_2_limit <= 1'b1;
              out_valid <= 1'b1;
              state <= ST_IDLE;
            end else begin
              out_1 <= pt(b_vec, (k == 5'h00) ? 5'h00 : k - 5'h01); // RL15 RL9
              out_1_limit <= 1'b1;
              ch <= 1'b1;
            end
          end else begin
            a0 <= pt(a_vec, k - 5'h01); // RL16
            b0 <= pt(b_vec, k - 5'h01); // RL16
            state <= ST_FAC;
          end
        end
        ST_FAC: begin
          // Strict ordering from the configurer keeps the divisor nonzero
          quot <= {dy_abs, 8'h00}; // RL8 RL5 RL6
          den <= {1'b0, dx_abs};
          neg <= dy[16] ^ dx[16];
          rem <= 18'h00000;
          steps <= `PWLC_DIV_STEPS;
          state <= ST_DIV;
        end
        ST_DIV: begin
          if (steps != 5'h00) begin
            steps <= steps - 5'h01;
            if (trial >= den) begin
              rem <= trial - den;
              quot <= {quot[23:0], 1'b1};
            end else begin
              rem <= trial;
              quot <= {quot[23:0], 1'b0};
            end
          end else begin
            grad <= neg ? -$signed({1'b0, quot}) : $signed({1'b0, quot}); // RL8
            state <= ST_OUT;
          end
        end
        ST_OUT: begin
          if (icpt_ready) begin
            if (ch) begin
              out_2 <= sat16(mulq(arg, grad) + icpt); // RL9 RL4
              out_2_limit <= 1'b0;
              out_valid <= 1'b1;
              state <= ST_IDLE;
            end else begin
              out_1 <= sat16(mulq(arg, grad) + icpt); // RL9 RL2
              out_1_limit <= 1'b0;
              ch <= 1'b1;
              state <= ST_SEL;
            end
          end else begin
            icpt <= $signed({{32{b0[15]}}, b0}) - mulq(a0, grad); // RL8
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Intercept takes one extra cycle so the multiply is not chained twice
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      icpt_ready <= 1'b0;
    end else begin
      icpt_ready <= (state == ST_OUT) && !icpt_ready;
    end
  end
endmodule // pwlc_characterizer
`default_nettype wire

// ==== pwlc_checker_asserts.sv ====
// Port-level assertions for the characterizer
`timescale 1ns/100ps
`default_nettype none
// ----------------
// Checker
// ----------------
module pwlc_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Results
  input wire logic out_valid,
  input wire logic [15:0] out_1,
  input wire logic [15:0] out_2,
  // Configuration
  input wire logic [335:0] curve_x,
  input wire logic [1:0] swap_sel,
  input wire logic [1:0] target_mode,
  input wire logic [15:0] man_1,
  input wire logic [15:0] man_2,
  // Status
  input wire logic [1:0] actual_mode,
  input wire logic cfg_error,
  input wire logic [4:0] npoints
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence auto_req; target_mode == 2'h2 ##1 !cfg_error; endsequence
  sequence man_req; target_mode == 2'h1 ##1 !cfg_error; endsequence
  sequence os_run; (actual_mode == 2'h0) [*4]; endsequence
  sequence man_run; (actual_mode == 2'h1) [*8]; endsequence
  a_err_forces_os:
    assert property (cfg_error |-> actual_mode == 2'h0) else $error("error without O/S");
  a_bad_swap_err:
    assert property (swap_sel != 2'h1 && swap_sel != 2'h2 |=> cfg_error)
    else $error("bad selector not flagged");
  a_first_inf_err:
    assert property (curve_x[15:0] == 16'h7fff |=> cfg_error) else $error("first X inf");
  a_auto_follow:
    assert property (auto_req |-> actual_mode == 2'h2) else $error("auto not entered");
  a_man_follow:
    assert property (man_req |-> actual_mode == 2'h1) else $error("manual not entered");
  a_os_silent:
    assert property (os_run |-> !out_valid) else $error("result while out of service");
  a_man_passthru:
    assert property (man_run |-> !out_valid || (out_1 == man_1 && out_2 == man_2))
    else $error("manual value not passed");
  a_one_point:
    assert property (curve_x[31:16] == 16'h7fff && curve_x[15:0] != 16'h7fff |=> npoints == 5'h01)
    else $error("point count wrong");
endmodule // pwlc_checker
bind pwlc_characterizer pwlc_checker chk_u (.mclk(mclk), .reset_n(reset_n),
  .out_valid(out_valid), .out_1(out_1), .out_2(out_2), .curve_x(curve_x),
  .swap_sel(swap_sel), .target_mode(target_mode), .man_1(man_1), .man_2(man_2),
  .actual_mode(actual_mode), .cfg_error(cfg_error), .npoints(npoints));
`default_nettype wire

// ==== pwlc_defs.vh ====
// Constants for the piecewise-linear curve characterizer
`ifndef PWLC_DEFS_VH
`define PWLC_DEFS_VH

// ----------------------------------------
// Data format
// ----------------------------------------
`define PWLC_W 16
`define PWLC_NPTS 21
`define PWLC_CURVE_BITS 336
`define PWLC_POS_INF 16'h7fff
`define PWLC_NEG_INF 16'h8000
`define PWLC_FRAC 8
`define PWLC_DIV_STEPS 5'h19

// ----------------------------------------
// Block modes and selector codes
// ----------------------------------------
`define PWLC_MODE_OS 2'h0
`define PWLC_MODE_MAN 2'h1
`define PWLC_MODE_AUTO 2'h2
`define PWLC_SWAP_OFF 2'h1
`define PWLC_SWAP_ON 2'h2

// ----------------------------------------
// Sample buffer
// ----------------------------------------
`define PWLC_FIFO_DEPTH 16
`define PWLC_FIFO_AW 4

`endif

// ==== pwlc_source.sv ====
// Upstream sample source feeding the characterizer
`timescale 1ns/100ps
`default_nettype none
// ----------------
// Source model
// ----------------
module pwlc_source (
  // Clock
  input wire logic mclk,
  // Sample handshake
  input wire logic in_ready,
  output var logic in_valid,
  output var logic [15:0] in_1,
  output var logic [15:0] in_2
);
  logic [31:0] q[$];
  logic tk;
  initial begin
    in_valid = 1'b0;
    in_1 = 16'h0000;
    in_2 = 16'h0000;
    forever begin
      @(posedge mclk);
      tk = in_valid && in_ready;
      #1;
      if (tk) void'(q.pop_front());
      if (q.size() > 0) begin
        in_valid = 1'b1;
        {in_2, in_1} = q[0];
      end else begin
        // Idle lines toggle so a stale word never passes for data
        in_valid = 1'b0;
        in_1 = ~in_1;
        in_2 = ~in_2;
      end
    end
  end
endmodule // pwlc_source
`default_nettype wire
